//--- pkg/rpc_pkg.sv
/*
 * Shared constants for the regulator power control register: offset,
 * field positions, reset value and timing of the memory power gate.
 * Assumes an 8-bit special-function-register space with 8-bit addresses.
 */
package rpc_pkg;

   localparam logic [7:0] REG_CTRL_OFFSET = 8'hC9;
   localparam logic [7:0] REG_CTRL_RESET = 8'h00;

   localparam int BIT_AUX_DISABLE = 7;
   localparam int BIT_BUS_POWER = 6;
   localparam int BIT_RSVD_HI = 5;
   localparam int BIT_AUX_LOW_POWER = 4;
   localparam int BIT_HALT_CORE_OFF = 3;
   localparam int BIT_RSVD_LO = 2;
   localparam int BIT_CORE_LOW_POWER = 1;
   localparam int BIT_MEM_GATING = 0;

   // Clocks skipped while the code memory supply settles.
   localparam int MEM_SETTLE_CLOCKS = 20;

   typedef enum logic [1:0] {
      RPC_MEM_ON = 2'b00,
      RPC_MEM_OFF = 2'b01,
      RPC_MEM_SETTLE = 2'b10
   } rpc_mem_state_t;

endpackage : rpc_pkg

//--- rtl/rpc_mem_gate.sv
/*
 * Code memory power gate. Powers the memory down between fetches when
 * gating is allowed, and on power-up holds off reads for a settle time.
 * Assumes i_fetch_req is a same-clock request from the fetch unit.
 */
`timescale 1ns/100ps
module rpc_mem_gate #(
   parameter int SETTLE_CLOCKS = rpc_pkg::MEM_SETTLE_CLOCKS
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Control
   input wire logic i_gate_allow,
   input wire logic i_fetch_req,
   // Memory side
   output logic o_mem_power_on,
   output logic o_fetch_stall
);

   localparam int CW = $clog2(SETTLE_CLOCKS + 1);

   initial begin
      if (SETTLE_CLOCKS < 1 || SETTLE_CLOCKS > 255) begin
         $error("SETTLE_CLOCKS out of range");
      end
   end

   rpc_pkg::rpc_mem_state_t state;
   rpc_pkg::rpc_mem_state_t next_state;
   logic [CW-1:0] count;

   always_comb begin
      next_state = state;
      case (state)
         rpc_pkg::RPC_MEM_ON: begin
            if (i_gate_allow && !i_fetch_req) begin
               next_state = rpc_pkg::RPC_MEM_OFF;
            end
         end
         rpc_pkg::RPC_MEM_OFF: begin
            if (i_fetch_req || !i_gate_allow) begin
               next_state = rpc_pkg::RPC_MEM_SETTLE;
            end
         end
         rpc_pkg::RPC_MEM_SETTLE: begin
            if (count == CW'(SETTLE_CLOCKS - 1)) begin
               next_state = rpc_pkg::RPC_MEM_ON;
            end
         end
         default: begin
            next_state = rpc_pkg::RPC_MEM_ON;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state <= rpc_pkg::RPC_MEM_ON;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         count <= '0;
      end else if (state == rpc_pkg::RPC_MEM_SETTLE) begin
         count <= count + CW'(1);
      end else begin
         count <= '0;
      end
   end

   // Power is restored as soon as settling starts, so it is up in time.
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_mem_power_on <= 1'b1;
      end else begin
         o_mem_power_on <= (next_state != rpc_pkg::RPC_MEM_OFF);
      end
   end

   assign o_fetch_stall = (state != rpc_pkg::RPC_MEM_ON);

endmodule : rpc_mem_gate

//--- rtl/rpc_regulator_ctrl.sv
/*
 * Regulator power control register with its power controls and the
 * code memory power gate.
 * Assumes a single-cycle register port on the system clock and an
 * asynchronous bus-power level from a pin.
 */
// Functional notes
// - Bit 7 set turns auxiliary regulator off.
// - Bit 6 reads live bus-power level.
// - Bit 4 selects auxiliary regulator low-power mode.
// - Bit 3 clear keeps core regulator in halt.
// - Bit 3 set shuts core regulator in halt.
// - Bit 1 selects core regulator low-power mode.
// - Bit 0 gates memory power between fetches.
// - Bit 0 clear keeps code memory powered.
// - Prefetch engine enabled overrides memory gating.
// - Memory power-up stalls fetch up to twenty-one clocks.
`timescale 1ns/100ps
module rpc_regulator_ctrl #(
   parameter int SETTLE_CLOCKS = rpc_pkg::MEM_SETTLE_CLOCKS
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // Device status
   input wire logic i_bus_power,
   input wire logic i_halt,
   input wire logic i_prefetch_en,
   input wire logic i_fetch_req,
   // Power controls
   output logic o_aux_regulator_en,
   output logic o_aux_regulator_low_power,
   output logic o_core_regulator_on,
   output logic o_core_regulator_low_power,
   output logic o_soft_reset_allowed,
   output logic o_mem_power_on,
   output logic o_fetch_stall
);

   ////////////////////////////////////////////////////////////////////////
   // Register storage.

   logic [7:0] ctrl;
   logic bus_power_meta;
   logic bus_power_sync;
   logic hit;

   assign hit = (i_addr == rpc_pkg::REG_CTRL_OFFSET);

   // The status bit position is never stored; it always shows the pin.
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         ctrl <= rpc_pkg::REG_CTRL_RESET;
      end else if (i_wr && hit) begin
         ctrl <= i_wdata;
         ctrl[rpc_pkg::BIT_BUS_POWER] <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         bus_power_meta <= 1'b0;
         bus_power_sync <= 1'b0;
      end else begin
         bus_power_meta <= i_bus_power;
         bus_power_sync <= bus_power_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read port; unmapped addresses read as zero.

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
      end else if (i_rd && hit) begin
         o_rdata <= ctrl;
         o_rdata[rpc_pkg::BIT_BUS_POWER] <= bus_power_sync;
      end else begin
         o_rdata <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Regulator controls.

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_aux_regulator_en <= 1'b1;
         o_aux_regulator_low_power <= 1'b0;
         o_core_regulator_low_power <= 1'b0;
      end else begin
         o_aux_regulator_en <= !ctrl[rpc_pkg::BIT_AUX_DISABLE];
         o_aux_regulator_low_power <=
            ctrl[rpc_pkg::BIT_AUX_LOW_POWER];
         // No interlock with the auxiliary regulator; software keeps it.
         o_core_regulator_low_power <=
            ctrl[rpc_pkg::BIT_CORE_LOW_POWER];
      end
   end

   // Shutting the core supply in halt leaves only the pin or a power
   // cycle able to wake the part, so soft reset sources are blocked.
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_core_regulator_on <= 1'b1;
         o_soft_reset_allowed <= 1'b1;
      end else if (i_halt && ctrl[rpc_pkg::BIT_HALT_CORE_OFF]) begin
         o_core_regulator_on <= 1'b0;
         o_soft_reset_allowed <= 1'b0;
      end else begin
         o_core_regulator_on <= 1'b1;
         o_soft_reset_allowed <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Code memory power gate.

   logic gate_allow;

   assign gate_allow = ctrl[rpc_pkg::BIT_MEM_GATING] && !i_prefetch_en;

   rpc_mem_gate #(
      .SETTLE_CLOCKS(SETTLE_CLOCKS)
   ) u_mem_gate (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_gate_allow(gate_allow),
      .i_fetch_req(i_fetch_req),
      .o_mem_power_on(o_mem_power_on),
      .o_fetch_stall(o_fetch_stall)
   );

endmodule : rpc_regulator_ctrl

//--- sim/rpc_chk_assertions.sv
/* Port checker for the regulator control register block.
   Assumes the block's single clock and asynchronous active-high reset. */
`timescale 1ns/100ps
module rpc_chk #(
   parameter int SETTLE_CLOCKS = 20
) (
   input wire logic i_clk_sys, i_rst, i_wr, i_rd,
   input wire logic [7:0] i_addr, i_wdata, o_rdata,
   input wire logic i_bus_power, i_halt, i_prefetch_en, i_fetch_req,
   input wire logic o_aux_regulator_en, o_aux_regulator_low_power,
   input wire logic o_core_regulator_on, o_core_regulator_low_power,
   input wire logic o_soft_reset_allowed, o_mem_power_on, o_fetch_stall
);
   localparam logic [7:0] ADR = rpc_pkg::REG_CTRL_OFFSET;
   // A shadow of the stored byte lets outputs be tied to past writes.
   logic [7:0] sh;
   logic hh;
   assign hh = i_halt & sh[3];
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) sh <= 8'h00;
      else if (i_wr && i_addr == ADR) sh <= i_wdata;
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   a_aux_enable: assert property (o_aux_regulator_en == !$past(sh[7]))
      else $error("aux enable wrong");
   a_halt_keep: assert property (!hh |=> o_core_regulator_on)
      else $error("core regulator dropped");
   a_halt_off: assert property (hh |=> !o_core_regulator_on)
      else $error("core regulator kept in halt");
   a_read_back: assert property (i_rd && i_addr == ADR |=>
      (o_rdata & 8'hBF) == (sh & 8'hBF)) else $error("read data wrong");
   a_rdata_idle: assert property (!(i_rd && i_addr == ADR) |=>
      o_rdata == 8'h00) else $error("read data not idle");
   a_prefetch_on: assert property (i_prefetch_en |=> o_mem_power_on)
      else $error("memory gated with prefetch");
   a_gate_off: assert property (!sh[0] |=> o_mem_power_on)
      else $error("memory gated while disabled");
   a_stall_end: assert property (i_fetch_req && o_fetch_stall |->
      ##[1:22] !o_fetch_stall) else $error("fetch stalled too long");
   c_halt: cover property (hh);
   c_fetch: cover property (i_fetch_req && o_fetch_stall);
   c_read: cover property (i_rd && i_addr == ADR);
endmodule : rpc_chk
bind rpc_regulator_ctrl rpc_chk #(.SETTLE_CLOCKS(SETTLE_CLOCKS)) u_chk (.*);

//--- sim/rpc_regulator_ctrl_tb.sv
/* Bench for the regulator control register block.
   Drives every input itself; the settle count is shortened to 2. */
`timescale 1ns/100ps
module rpc_regulator_ctrl_tb;
   localparam logic [7:0] ADR = rpc_pkg::REG_CTRL_OFFSET;
   logic i_clk_sys = 1'h0, i_rst = 1'h1, i_wr = 1'h0, i_rd = 1'h0;
   logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, rv;
   logic i_bus_power = 1'h0, i_halt = 1'h0;
   logic i_prefetch_en = 1'h0, i_fetch_req = 1'h0;
   logic o_aux_regulator_en, o_aux_regulator_low_power, o_core_regulator_on;
   logic o_core_regulator_low_power, o_soft_reset_allowed;
   logic o_mem_power_on, o_fetch_stall;
   int err_count = 0, n_checks = 0, cyc = 0;
   always #4 i_clk_sys = ~i_clk_sys;
   rpc_regulator_ctrl #(.SETTLE_CLOCKS(2)) u_dut (.*);
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      n_checks++;
      if (e !== g) begin
         err_count++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge i_clk_sys);
      i_wr <= 1'h1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk_sys);
      i_wr <= 1'h0;
   endtask : wr
   task automatic rd(logic [7:0] a);
      @(posedge i_clk_sys);
      i_rd <= 1'h1;
      i_addr <= a;
      @(posedge i_clk_sys);
      i_rd <= 1'h0;
      @(negedge i_clk_sys) rv = o_rdata;
   endtask : rd
   task automatic wt(int n);
      repeat (n) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
   endtask : wt
   task automatic t_fields();
      logic [7:0] v [6] = '{8'h80, 8'h10, 8'h02, 8'h24, 8'hFF, 8'h00};
      foreach (v[k]) begin
         @(posedge i_clk_sys) i_bus_power <= k[0];
         wr(ADR, v[k]);
         rd(ADR);
         chk("reg", (v[k] & 8'hBF) | (k[0] ? 8'h40 : 8'h00), rv);
         chk("aux_en", !v[k][7], o_aux_regulator_en);
         chk("aux_lp", v[k][4], o_aux_regulator_low_power);
         chk("core_lp", v[k][1], o_core_regulator_low_power);
      end
      $display("t_fields done");
   endtask : t_fields
   task automatic t_other();
      rd(ADR);
      chk("reset", 8'h00, rv);
      t_fields();
      wr(8'hC8, 8'hFF);
      rd(8'hC8);
      chk("unmapped", 8'h00, rv);
      rd(ADR);
      chk("kept", 8'h40, rv);
      $display("t_other done");
   endtask : t_other
   task automatic t_halt();
      wr(ADR, 8'h08);
      @(posedge i_clk_sys) i_halt <= 1'h1;
      wt(2);
      chk("core_on", 8'h00, o_core_regulator_on);
      chk("soft_rst", 8'h00, o_soft_reset_allowed);
      wr(ADR, 8'h00);
      wt(2);
      chk("core_on", 8'h01, o_core_regulator_on);
      chk("soft_rst", 8'h01, o_soft_reset_allowed);
      @(posedge i_clk_sys) i_halt <= 1'h0;
      $display("t_halt done");
   endtask : t_halt
   task automatic t_gate();
      int n;
      n = 0;
      wr(ADR, 8'h01);
      wt(3);
      chk("mem_on", 8'h00, o_mem_power_on);
      chk("stall", 8'h01, o_fetch_stall);
      @(posedge i_clk_sys) i_fetch_req <= 1'h1;
      do begin
         @(negedge i_clk_sys);
         n++;
      end while (o_fetch_stall === 1'h1 && n < 40);
      chk("settle", 8'd4, n[7:0]);
      @(posedge i_clk_sys) i_prefetch_en <= 1'h1;
      i_fetch_req <= 1'h0;
      wt(3);
      chk("pf_on", 8'h01, o_mem_power_on);
      @(posedge i_clk_sys) i_prefetch_en <= 1'h0;
      wt(3);
      chk("gated", 8'h00, o_mem_power_on);
      wr(ADR, 8'h00);
      wt(2);
      chk("mem_on", 8'h01, o_mem_power_on);
      $display("t_gate done");
   endtask : t_gate
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize
   // A hang is cut short well beyond the fewer than a hundred cycles the run needs.
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         err_count++;
         summarize();
      end
   end
   initial begin
      repeat (4) @(posedge i_clk_sys);
      i_rst <= 1'h0;
      t_other();
      t_halt();
      t_gate();
      summarize();
   end
endmodule : rpc_regulator_ctrl_tb
